// [sse_cfg.svh]
`ifndef SSE_CFG_SVH
`define SSE_CFG_SVH
// register byte offsets
`define SSE_REQ_OFF 12'h000
`define SSE_CMD_OFF 12'h004
`define SSE_RSP_OFF 12'h008
`define SSE_REC_OFF 12'h00c
`define SSE_CFG_OFF 12'h010
`define SSE_UPD_OFF 12'h014
`define SSE_ST_OFF 12'h018
`define SSE_REC_BASE 12'h040
// field positions
`define SSE_HANDLE_LSB 0
`define SSE_MASK_LSB 16
`define SSE_RSVD_LSB 24
// codes and limits
`define SSE_CODE_OK 8'h00
`define SSE_CODE_UNKNOWN 8'h80
`define SSE_HANDLE_RSVD_LO 16'h0000
`define SSE_HANDLE_RSVD_HI 16'hffff
`define SSE_DEF_HANDLE 16'h0001
`define SSE_DEF_COUNT 4'h1
`define SSE_STATE_UNKNOWN 8'h00
`endif

// [sse_pkg.sv]
package sse_pkg;
    typedef enum logic [1:0] {
        SSE_IDLE = 2'b00,
        SSE_EXEC = 2'b01,
        SSE_DONE = 2'b10
    } sse_state_e;
endpackage

// [sse_core.sv]
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "sse_cfg.svh"
module sse_core
    import sse_pkg::*;
#(
    parameter int NSETS = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NSETS*8-1:0] sensor_operating_condition,
    input wire logic [NSETS*8-1:0] sensor_state_in,
    input wire logic [NSETS*8-1:0] sensor_event_in,
    input wire logic [NSETS-1:0] sensor_event_strobe,
    output logic [NSETS-1:0] rearm_pulse
);
    logic [31:0] req_reg;
    logic [15:0] handle_cfg_reg;
    logic [3:0] count_cfg_reg;
    logic [NSETS-1:0] known_reg;
    logic [7:0] cur_reg [NSETS];
    logic [7:0] prior_reg [NSETS];
    logic [7:0] evt_reg [NSETS];
    logic [7:0] cond_reg [NSETS];
    logic [7:0] result_code_reg;
    logic [3:0] rsp_count_reg;
    logic [NSETS-1:0] rearm_reg;
    sse_state_e state_reg;
    logic [31:0] rdata_next;
    logic setup_wr, wr_en, rd_en, hit, start, handle_ok;
    logic [15:0] req_handle;
    logic [NSETS-1:0] count_mask;
    logic [NSETS-1:0] samp1_reg, samp2_reg;
    logic [7:0] st1_reg [NSETS];
    logic [7:0] st2_reg [NSETS];
    logic [7:0] ev1_reg [NSETS];
    logic [7:0] ev2_reg [NSETS];
    logic [7:0] oc1_reg [NSETS];
    logic [7:0] oc2_reg [NSETS];

    // bus strobes, zero wait states
    assign setup_wr = psel & ~penable;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign start = wr_en && paddr == `SSE_CMD_OFF && pwdata[0] && state_reg == SSE_IDLE;
    assign req_handle = req_reg[`SSE_HANDLE_LSB +: 16];
    // reserved handles and foreign handles are unknown
    assign handle_ok = req_handle != `SSE_HANDLE_RSVD_LO && req_handle != `SSE_HANDLE_RSVD_HI
        && req_handle == handle_cfg_reg;

    // set count mask, clamp to range 1..NSETS
    always_comb begin
        count_mask = '0;
        for (int i = 0; i < NSETS; i++) begin
            if (i < int'(count_cfg_reg) || i == 0) begin
                count_mask[i] = 1'b1;
            end
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg <= 32'h0000_0000;
            handle_cfg_reg <= `SSE_DEF_HANDLE;
            count_cfg_reg <= `SSE_DEF_COUNT;
        end else if (wr_en) begin
            if (paddr == `SSE_REQ_OFF && state_reg == SSE_IDLE) begin
                req_reg <= pwdata;
            end
            if (paddr == `SSE_CFG_OFF) begin
                handle_cfg_reg <= pwdata[15:0];
                if (pwdata[19:16] >= 4'h1 && int'(pwdata[19:16]) <= NSETS) begin
                    count_cfg_reg <= pwdata[19:16];
                end
            end
        end
    end

    // command sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SSE_IDLE;
            result_code_reg <= `SSE_CODE_OK;
            rsp_count_reg <= 4'h0;
            rearm_reg <= '0;
        end else begin
            rearm_reg <= '0;
            case (state_reg)
                SSE_IDLE: begin
                    if (start) begin
                        state_reg <= SSE_EXEC;
                    end
                end
                SSE_EXEC: begin
                    if (handle_ok) begin
                        result_code_reg <= `SSE_CODE_OK;
                        rsp_count_reg <= count_cfg_reg;
                        rearm_reg <= req_reg[`SSE_MASK_LSB +: NSETS] & count_mask;
                    end else begin
                        result_code_reg <= `SSE_CODE_UNKNOWN;
                        rsp_count_reg <= 4'h0;
                    end
                    state_reg <= SSE_DONE;
                end
                SSE_DONE: begin
                    state_reg <= SSE_IDLE;
                end
                default: begin
                    state_reg <= SSE_IDLE;
                end
            endcase
        end
    end

    assign rearm_pulse = rearm_reg;

    // per-set sensor tracking with pin synchronisers
    for (genvar g = 0; g < NSETS; g++) begin : g_set
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                st1_reg[g] <= `SSE_STATE_UNKNOWN;
                st2_reg[g] <= `SSE_STATE_UNKNOWN;
                ev1_reg[g] <= `SSE_STATE_UNKNOWN;
                ev2_reg[g] <= `SSE_STATE_UNKNOWN;
                oc1_reg[g] <= 8'h00;
                oc2_reg[g] <= 8'h00;
                samp1_reg[g] <= 1'b0;
                samp2_reg[g] <= 1'b0;
            end else begin
                st1_reg[g] <= sensor_state_in[g*8 +: 8];
                st2_reg[g] <= st1_reg[g];
                ev1_reg[g] <= sensor_event_in[g*8 +: 8];
                ev2_reg[g] <= ev1_reg[g];
                oc1_reg[g] <= sensor_operating_condition[g*8 +: 8];
                oc2_reg[g] <= oc1_reg[g];
                samp1_reg[g] <= sensor_event_strobe[g];
                samp2_reg[g] <= samp1_reg[g];
            end
        end

        // assessment of current and prior state
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cur_reg[g] <= `SSE_STATE_UNKNOWN;
                prior_reg[g] <= `SSE_STATE_UNKNOWN;
                evt_reg[g] <= `SSE_STATE_UNKNOWN;
                cond_reg[g] <= 8'h00;
                known_reg[g] <= 1'b0;
            end else begin
                cond_reg[g] <= oc2_reg[g];
                cur_reg[g] <= st2_reg[g];
                if (!known_reg[g] || rearm_reg[g]) begin
                    prior_reg[g] <= st2_reg[g];
                    known_reg[g] <= 1'b1;
                end else if (st2_reg[g] != cur_reg[g]) begin
                    // an unknown earlier state leaves prior equal to current
                    if (cur_reg[g] == `SSE_STATE_UNKNOWN) begin
                        prior_reg[g] <= st2_reg[g];
                    end else begin
                        prior_reg[g] <= cur_reg[g];
                    end
                end
                if (samp2_reg[g]) begin
                    evt_reg[g] <= ev2_reg[g];
                end
            end
        end
    end

    // read mux
    always_comb begin
        rdata_next = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            `SSE_REQ_OFF: rdata_next = req_reg;
            `SSE_CMD_OFF: rdata_next = 32'h0000_0000;
            `SSE_RSP_OFF: rdata_next = {20'h00000, rsp_count_reg, result_code_reg};
            `SSE_CFG_OFF: rdata_next = {12'h000, count_cfg_reg, handle_cfg_reg};
            `SSE_ST_OFF: rdata_next = {30'h0, state_reg};
            default: begin
                hit = 1'b0;
                for (int i = 0; i < NSETS; i++) begin
                    if (paddr == `SSE_REC_BASE + 12'(i * 4)) begin
                        hit = 1'b1;
                        rdata_next = {evt_reg[i], prior_reg[i], cur_reg[i], cond_reg[i]};
                    end
                end
            end
        endcase
    end

    // registered bus answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_wr;
            pslverr <= setup_wr & ~hit;
            if (rd_en) begin
                prdata <= rdata_next;
            end
        end
    end
endmodule

// [sse_sensor_model.sv]
`timescale 1ns/1ns
// sensor field: registered states, event byte ahead of a late strobe
module sse_sensor_model #(parameter int NSETS = 8) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NSETS*8-1:0] state_cmd,
    output logic [NSETS*8-1:0] cond,
    output logic [NSETS*8-1:0] state,
    output logic [NSETS*8-1:0] evt,
    output logic [NSETS-1:0] strobe
);
    logic [NSETS-1:0] chg;
    // condition byte of set i is i, so order is visible
    always_comb begin
        for (int i = 0; i < NSETS; i++) cond[i*8+:8] = i[7:0];
    end
    // strobe lags the event byte so a slow sampler sees it stable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
            evt <= '0;
            chg <= '0;
            strobe <= '0;
        end else begin
            for (int i = 0; i < NSETS; i++) chg[i] <= state_cmd[i*8+:8] != state[i*8+:8];
            state <= state_cmd;
            evt <= state_cmd;
            strobe <= chg;
        end
    end
endmodule

// [sse_checker.sv]
`timescale 1ns/1ns
`include "sse_cfg.svh"
module sse_checker #(parameter int NSETS = 8) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NSETS-1:0] rearm_pulse
);
    // one clock domain
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic rsp_rd = pready && !pwrite && paddr == `SSE_RSP_OFF;
    wire logic cmd_wr = psel && penable && pwrite && paddr == `SSE_CMD_OFF && pwdata[0];
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray ready");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_err_unmapped: assert property (psel && penable && paddr == 12'h0f0 |-> pslverr)
        else $error("unmapped not refused");
    a_code_legal: assert property (rsp_rd |-> prdata[7:0] inside {8'h00, 8'h80})
        else $error("illegal result code");
    a_count_range: assert property (rsp_rd && prdata[7:0] == 8'h00 |-> prdata[11:8] inside {[1:8]})
        else $error("count out of range");
    a_rearm_cause: assert property (|rearm_pulse |-> $past(cmd_wr, 2))
        else $error("rearm without command");
    a_rearm_pulse: assert property (|rearm_pulse |=> rearm_pulse == '0)
        else $error("rearm not a pulse");
    c_rearm: cover property (|rearm_pulse);
    c_err: cover property (pslverr);
    c_unknown: cover property (rsp_rd && prdata[7:0] == 8'h80);
endmodule
bind sse_core sse_checker #(.NSETS(NSETS)) sse_checker_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rearm_pulse(rearm_pulse));

// [tb_state_sensor_reading_command.sv]
`timescale 1ns/1ns
`include "sse_cfg.svh"
module tb_state_sensor_reading_command;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [63:0] cond, state, evt, state_cmd;
    logic [7:0] strobe, rearm_pulse, seen;
    int fail_count = 0, compares = 0;
    sse_core #(.NSETS(8)) sse_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sensor_operating_condition(cond),
        .sensor_state_in(state), .sensor_event_in(evt), .sensor_event_strobe(strobe),
        .rearm_pulse(rearm_pulse));
    sse_sensor_model sse_sensor_model_inst (.pclk(pclk), .presetn(presetn),
        .state_cmd(state_cmd), .cond(cond), .state(state), .evt(evt), .strobe(strobe));
    initial forever #5 pclk = ~pclk;
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    // one bus transfer, held until ready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // issue one read command and judge code, count and rearms
    task run(input logic [15:0] h, input logic [7:0] m, input logic [11:0] rsp, input logic [7:0] re);
        apb(1, `SSE_REQ_OFF, {8'h00, m, h});
        apb(1, `SSE_CMD_OFF, 32'h1);
        seen = '0;
        repeat (4) begin
            @(posedge pclk);
            seen |= rearm_pulse;
        end
        chk({24'h0, seen}, {24'h0, re}, "rearm set");
        apb(0, `SSE_RSP_OFF, '0);
        chk(rd & 32'hfff, {20'h0, rsp}, "code and count");
    endtask
    task t_known;
        apb(1, `SSE_CFG_OFF, 32'h0003_0005);
        run(16'h0005, 8'h85, 12'h300, 8'h05);
        for (int i = 0; i < 8; i++) begin
            apb(0, `SSE_REC_BASE + 12'(4 * i), '0);
            chk(rd, {state_cmd[i*8+:8], state_cmd[i*8+:8], state_cmd[i*8+:8], 8'(i)},
                "record");
        end
        $display("test known done");
    endtask
    task t_prior;
        state_cmd[7:0] <= 8'h3c;
        repeat (10) @(posedge pclk);
        apb(0, `SSE_REC_BASE, '0);
        chk(rd, 32'h3c10_3c00, "prior after change");
        $display("test prior done");
    endtask
    task t_reserved;
        logic [15:0] hs [3] = '{16'h0000, 16'hffff, 16'h0006};
        logic [15:0] cf [3] = '{16'h0000, 16'hffff, 16'h0005};
        // reserved handles stay unknown even when configured as the sensor handle
        foreach (hs[k]) begin
            apb(1, `SSE_CFG_OFF, {16'h0003, cf[k]});
            run(hs[k], 8'hff, 12'h080, 8'h00);
        end
        $display("test reserved done");
    endtask
    task t_unmapped;
        apb(0, 12'h0f0, '0);
        chk({31'h0, err}, 32'h1, "unmapped accepted");
        // count nine is refused, handle still taken
        apb(1, `SSE_CFG_OFF, 32'h0009_0007);
        apb(0, `SSE_CFG_OFF, '0);
        chk(rd, 32'h0003_0007, "count nine accepted");
        apb(0, `SSE_ST_OFF, '0);
        chk(rd, 32'h0000_0000, "sequencer not idle");
        // widest set count rearms every set
        apb(1, `SSE_CFG_OFF, 32'h0008_0007);
        run(16'h0007, 8'hff, 12'h800, 8'hff);
        $display("test unmapped done");
    endtask
    task print_verdict;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 8; i++) state_cmd[i*8+:8] = 8'h10 + 8'(i);
        repeat (4) @(posedge pclk);
        presetn <= 1;
        t_known;
        t_prior;
        t_reserved;
        t_unmapped;
        print_verdict;
    end
    // watchdog
    initial begin
        #100000;
        fail_count++;
        $display("ERROR %0t watchdog expired", $time);
        print_verdict;
    end
endmodule
